// >>> rtl/slt_pkg.sv
// shared constants and types for the sector lock and training register bank
package slt_pkg;

  // ==========================================================
  // pin bundle layout (sync stage order)
  localparam int          PIN_W        = 3;
  localparam int          PIN_SCK      = 0;
  localparam int          PIN_CS       = 1;
  localparam int          PIN_SI       = 2;
  localparam logic [2:0]  PIN_IDLE     = 3'h2;  // sck low, select high, data low

  // ==========================================================
  // sector geometry
  localparam int          SECTORS      = 512;
  localparam int          SEC_IDX_W    = 9;
  localparam int          SEC_LSB      = 16;    // 64 KB sectors

  // ==========================================================
  // lock access codes
  localparam logic [7:0]  LOCK_ON      = 8'h00; // sector protected
  localparam logic [7:0]  LOCK_OFF     = 8'hFF; // sector not protected

  // ==========================================================
  // delivery values
  localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
  localparam logic [7:0]  STATUS1_SHIP = 8'h00;
  localparam logic [7:0]  CONFIG1_SHIP = 8'h00;
  localparam logic [7:0]  BOOT_SHIP    = 8'h00;
  localparam logic [63:0] PASS_SHIP    = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [15:0] APR_SHIP     = 16'hFE7F;
  localparam logic [7:0]  STORED_RESET = 8'h00;
  localparam logic [7:0]  WORK_OFF     = 8'h00; // pattern output disabled
  localparam int          OTP_IDX_W    = 10;    // 1024 bytes
  localparam logic [9:0]  OTP_RANDOM_N = 10'h010;
  // random factory value; arbitrary
  localparam logic [127:0] OTP_SEED    = 128'h5A3C_96E1_0F7B_24D8_C16E_9A05_B3F2_7D48;

  // ==========================================================
  // command codes
  localparam logic [7:0]  CMD_RD_STATUS = 8'h05;
  localparam logic [7:0]  CMD_RD_CFG    = 8'h35;
  localparam logic [7:0]  CMD_RD_BOOT   = 8'h14;
  localparam logic [7:0]  CMD_RD_APR    = 8'h2B;
  localparam logic [7:0]  CMD_RD_PASS   = 8'hE7;
  localparam logic [7:0]  CMD_RD_DYN    = 8'hE0;
  localparam logic [7:0]  CMD_WR_DYN    = 8'hE1;
  localparam logic [7:0]  CMD_RD_PERS   = 8'hE2;
  localparam logic [7:0]  CMD_WR_PERS   = 8'hE3;
  localparam logic [7:0]  CMD_RD_STORED = 8'h41;
  localparam logic [7:0]  CMD_PG_STORED = 8'h43;
  localparam logic [7:0]  CMD_RD_WORK   = 8'h4A;
  localparam logic [7:0]  CMD_WR_WORK   = 8'h4B;
  localparam logic [7:0]  CMD_RD_OTP    = 8'h4C;
  localparam logic [7:0]  CMD_DDR_RD    = 8'hEE;

  // ==========================================================
  // frame bit counts (last bit index)
  localparam logic [5:0]  LAST_OPC     = 6'h07;
  localparam logic [5:0]  LAST_ADDR    = 6'h1F;
  localparam logic [5:0]  LAST_DATA    = 6'h07;
  localparam logic [5:0]  LAST_DUMMY   = 6'h07;

  // command frame phases
  typedef enum logic [2:0] {ST_OPC, ST_ADDR, ST_DATA, ST_DUMMY, ST_OUT, ST_SKIP} slt_state_t;

endpackage : slt_pkg

// >>> rtl/slt_pin_if.sv
// raw and filtered serial pin levels between core and synchroniser
`timescale 1ns/100ps
interface slt_pin_if;
  logic [2:0] raw;    // pin levels straight from the pads
  logic [2:0] clean;  // synchronised, agreed levels
  modport sync (input raw, output clean);
  modport core (output raw, input clean);
endinterface : slt_pin_if

// >>> rtl/slt_pin_sync.sv
// three-stage synchroniser with agreement filter for the serial pins
`timescale 1ns/100ps
module slt_pin_sync (
  // clocking
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // pins
  slt_pin_if.sync   pins
);
  // ==========================================================
  // stages
  logic [2:0] stage1;  // metastable catcher, read only by stage2
  logic [2:0] stage2;
  logic [2:0] stage3;

  // shift pins through three flops
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= slt_pkg::PIN_IDLE;
      stage2 <= slt_pkg::PIN_IDLE;
      stage3 <= slt_pkg::PIN_IDLE;
    end else if (ce) begin
      stage1 <= pins.raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a bit changes only once stage2 and stage3 agree, filtering single-cycle glitches
  always_ff @(posedge clk) begin
    if (rst) begin
      pins.clean <= slt_pkg::PIN_IDLE;
    end else if (ce) begin
      for (int i = 0; i < slt_pkg::PIN_W; i++) begin
        if (stage2[i] == stage3[i]) begin
          pins.clean[i] <= stage3[i];
        end
      end
    end
  end
endmodule : slt_pin_sync

// >>> rtl/slt_top.sv
// sector lock and training pattern register bank behind the serial command port
//
// Behaviour
// - writing 00h clears sector dynamic lock
// - dynamic value FFh leaves sector unlocked
// - drive learning pattern during read dummy cycles
// - working copy enables and supplies pattern
// - host may rewrite working pattern anytime
// - shipped array reads all FFh
// - OTP first 16 bytes random, rest FFh
// - status, config, boot 00h; persistent bits one
// - shipped password is all ones
// - shipped protection register reads FE7Fh
// - persistent 00h protects, FFh unprotects sector
`timescale 1ns/100ps
module slt_top (
  // clock, reset, enable
  input  wire logic CLOCK,
  input  wire logic RST,
  input  wire logic CE,
  // serial link from the host
  input  wire logic SCK,
  input  wire logic CS_N,
  input  wire logic SI,
  // serial data back to the host
  output logic      SO,
  output logic      SO_OE,
  // protection state of the last addressed sector
  output logic      WRITE_ALLOWED
);
  // ==========================================================
  // pin synchronisation
  slt_pin_if pins ();                     // raw and agreed pin levels
  assign pins.raw = {SI, CS_N, SCK};

  slt_pin_sync u_sync (
    .clk  (CLOCK),
    .rst  (RST),
    .ce   (CE),
    .pins (pins)
  );

  wire sck_c  = pins.clean[slt_pkg::PIN_SCK];
  wire cs_n_c = pins.clean[slt_pkg::PIN_CS];
  wire si_c   = pins.clean[slt_pkg::PIN_SI];

  // ==========================================================
  // state
  slt_pkg::slt_state_t state, next_state;  // command frame phase
  logic [5:0]          cnt, next_cnt;      // bit counter within phase
  logic [7:0]          opcode;             // captured command
  logic [31:0]         addr;               // captured address
  logic [31:0]         in_sr;              // input shifter
  logic [63:0]         out_sr, next_out;   // output shifter, ones fill in behind
  logic                next_so;
  logic                next_oe;
  logic                sck_q;              // previous agreed clock level
  logic                cs_n_q;             // previous agreed select level
  logic [slt_pkg::SECTORS-1:0] dyn_lock;   // 1 = dynamic lock open
  logic [slt_pkg::SECTORS-1:0] pers_lock;  // 1 = persistent lock open
  logic [7:0]          stored;             // stored training value
  logic [7:0]          working;            // working training value

  // ==========================================================
  // helpers
  // sector index of an address
  function automatic logic [slt_pkg::SEC_IDX_W-1:0] sec_of(input logic [31:0] adr);
    sec_of = adr[slt_pkg::SEC_LSB +: slt_pkg::SEC_IDX_W];
  endfunction : sec_of

  // only the two documented codes change a lock; others are ignored
  function automatic logic lock_valid(input logic [7:0] val);
    lock_valid = (val == slt_pkg::LOCK_ON) || (val == slt_pkg::LOCK_OFF);
  endfunction : lock_valid

  // lock bit presented as an access byte
  function automatic logic [7:0] lock_byte(input logic open);
    lock_byte = open ? slt_pkg::LOCK_OFF : slt_pkg::LOCK_ON;
  endfunction : lock_byte

  // commands that carry an address
  function automatic logic needs_addr(input logic [7:0] opc);
    needs_addr = (opc == slt_pkg::CMD_RD_DYN) || (opc == slt_pkg::CMD_WR_DYN) ||
                 (opc == slt_pkg::CMD_RD_PERS) || (opc == slt_pkg::CMD_WR_PERS) ||
                 (opc == slt_pkg::CMD_RD_OTP) || (opc == slt_pkg::CMD_DDR_RD);
  endfunction : needs_addr

  // commands that carry a data byte
  function automatic logic needs_data(input logic [7:0] opc);
    needs_data = (opc == slt_pkg::CMD_WR_DYN) || (opc == slt_pkg::CMD_WR_PERS) ||
                 (opc == slt_pkg::CMD_WR_WORK) || (opc == slt_pkg::CMD_PG_STORED);
  endfunction : needs_data

  // register reads answered straight after the opcode; an explicit list,
  // so a stored or working value of FFh still counts as a reply
  function automatic logic is_reg_read(input logic [7:0] opc);
    is_reg_read = (opc == slt_pkg::CMD_RD_STATUS) || (opc == slt_pkg::CMD_RD_CFG) ||
                  (opc == slt_pkg::CMD_RD_BOOT) || (opc == slt_pkg::CMD_RD_APR) ||
                  (opc == slt_pkg::CMD_RD_PASS) || (opc == slt_pkg::CMD_RD_STORED) ||
                  (opc == slt_pkg::CMD_RD_WORK);
  endfunction : is_reg_read

  // one-time area byte: random head, erased rest
  function automatic logic [7:0] otp_byte(input logic [31:0] adr);
    logic [7:0] head;
    head = slt_pkg::OTP_SEED[8'(127 - 8 * int'(adr[3:0])) -: 8];
    otp_byte = (adr[slt_pkg::OTP_IDX_W-1:0] < slt_pkg::OTP_RANDOM_N) ? head : slt_pkg::ERASED_BYTE;
  endfunction : otp_byte

  // reply word for a read command, left aligned, ones behind
  function automatic logic [63:0] reply(input logic [7:0] opc, input logic [31:0] adr);
    case (opc)
      slt_pkg::CMD_RD_STATUS: reply = {slt_pkg::STATUS1_SHIP, {56{1'b1}}};
      slt_pkg::CMD_RD_CFG:    reply = {slt_pkg::CONFIG1_SHIP, {56{1'b1}}};
      slt_pkg::CMD_RD_BOOT:   reply = {slt_pkg::BOOT_SHIP, {56{1'b1}}};
      slt_pkg::CMD_RD_APR:    reply = {slt_pkg::APR_SHIP, {48{1'b1}}};
      slt_pkg::CMD_RD_PASS:   reply = slt_pkg::PASS_SHIP;
      slt_pkg::CMD_RD_STORED: reply = {stored, {56{1'b1}}};
      slt_pkg::CMD_RD_WORK:   reply = {working, {56{1'b1}}};
      slt_pkg::CMD_RD_DYN:    reply = {lock_byte(dyn_lock[sec_of(adr)]), {56{1'b1}}};
      slt_pkg::CMD_RD_PERS:   reply = {lock_byte(pers_lock[sec_of(adr)]), {56{1'b1}}};
      slt_pkg::CMD_RD_OTP:    reply = {otp_byte(adr), {56{1'b1}}};
      default:                reply = {64{1'b1}};                                // erased array
    endcase
  endfunction : reply

  // ==========================================================
  // edge and strobe decode
  wire        cs_act    = ~cs_n_c;
  wire        sck_rise  = CE & cs_act & sck_c & ~sck_q;   // host drives, we sample
  wire        sck_fall  = CE & cs_act & ~sck_c & sck_q;   // we shift out
  wire        cs_end    = CE & cs_n_c & ~cs_n_q;          // frame closed
  wire [31:0] in_word   = {in_sr[30:0], si_c};
  wire [7:0]  in_byte   = in_word[7:0];
  wire [slt_pkg::SEC_IDX_W-1:0] sec_idx = sec_of(addr);
  wire        op_done   = sck_rise && (state == slt_pkg::ST_OPC) && (cnt == slt_pkg::LAST_OPC);
  wire        addr_done = sck_rise && (state == slt_pkg::ST_ADDR) && (cnt == slt_pkg::LAST_ADDR);
  wire        data_done = sck_rise && (state == slt_pkg::ST_DATA) && (cnt == slt_pkg::LAST_DATA);
  wire        wr_dyn    = data_done && (opcode == slt_pkg::CMD_WR_DYN);
  wire        wr_pers   = data_done && (opcode == slt_pkg::CMD_WR_PERS);
  wire        wr_work   = data_done && (opcode == slt_pkg::CMD_WR_WORK);
  wire        wr_stored = data_done && (opcode == slt_pkg::CMD_PG_STORED);
  wire        pattern_on = (working != slt_pkg::WORK_OFF);
  wire        is_read   = is_reg_read(in_byte);

  // ==========================================================
  // frame sequencer, next values
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_out   = out_sr;
    next_so    = SO;
    next_oe    = SO_OE;
    if (cs_end) begin
      // frame over: release the line, expect an opcode next
      next_state = slt_pkg::ST_OPC;
      next_cnt   = '0;
      next_oe    = 1'b0;
    end else if (sck_rise) begin
      next_cnt = cnt + 6'h01;
      case (state)
        slt_pkg::ST_OPC: begin
          if (cnt == slt_pkg::LAST_OPC) begin
            next_cnt = '0;
            if (needs_addr(in_byte)) begin
              next_state = slt_pkg::ST_ADDR;
            end else if (needs_data(in_byte)) begin
              next_state = slt_pkg::ST_DATA;
            end else if (is_read) begin
              next_out   = reply(in_byte, addr);
              next_state = slt_pkg::ST_OUT;
            end else begin
              next_state = slt_pkg::ST_SKIP;   // unknown code: stay silent
            end
          end
        end
        slt_pkg::ST_ADDR: begin
          if (cnt == slt_pkg::LAST_ADDR) begin
            next_cnt = '0;
            if (opcode == slt_pkg::CMD_DDR_RD) begin
              next_out   = {working, {56{1'b1}}};
              next_state = slt_pkg::ST_DUMMY;
            end else if (needs_data(opcode)) begin
              next_state = slt_pkg::ST_DATA;
            end else begin
              next_out   = reply(opcode, in_word);
              next_state = slt_pkg::ST_OUT;
            end
          end
        end
        slt_pkg::ST_DATA: begin
          if (cnt == slt_pkg::LAST_DATA) begin
            next_state = slt_pkg::ST_SKIP;
          end
        end
        slt_pkg::ST_DUMMY: begin
          if (cnt == slt_pkg::LAST_DUMMY) begin
            next_out   = {64{1'b1}};                             // erased array data
            next_state = slt_pkg::ST_OUT;
          end
        end
        default: begin
          next_cnt = cnt;                                        // skip and out hold the count
        end
      endcase
    end else if (sck_fall) begin
      // shift out on the falling edge so the host samples a settled bit
      if ((state == slt_pkg::ST_OUT) || (state == slt_pkg::ST_DUMMY)) begin
        next_so  = out_sr[63];
        next_out = {out_sr[62:0], 1'b1};
        next_oe  = (state == slt_pkg::ST_OUT) || pattern_on;
      end
    end
  end

  // ==========================================================
  // sequencer registers
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state  <= slt_pkg::ST_OPC;
      cnt    <= '0;
      out_sr <= '1;
      SO     <= 1'b0;
      SO_OE  <= 1'b0;
    end else if (CE) begin
      state  <= next_state;
      cnt    <= next_cnt;
      out_sr <= next_out;
      SO     <= next_so;
      SO_OE  <= next_oe;
    end
  end

  // edge history and input capture
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      sck_q  <= 1'b0;
      cs_n_q <= 1'b1;
      in_sr  <= '0;
      opcode <= '0;
      addr   <= '0;
    end else if (CE) begin
      sck_q  <= sck_c;
      cs_n_q <= cs_n_c;
      if (sck_rise) in_sr <= in_word;
      if (op_done) opcode <= in_byte;
      if (addr_done) addr <= in_word;
    end
  end

  // ==========================================================
  // lock arrays; odd codes leave the bit alone
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      dyn_lock  <= '1;
      pers_lock <= '1;
    end else if (CE) begin
      if (wr_dyn && lock_valid(in_byte)) dyn_lock[sec_idx] <= (in_byte == slt_pkg::LOCK_OFF);
      if (wr_pers && lock_valid(in_byte)) pers_lock[sec_idx] <= (in_byte == slt_pkg::LOCK_OFF);
    end
  end

  // training values; working copy starts as the stored value
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      stored  <= slt_pkg::STORED_RESET;
      working <= slt_pkg::STORED_RESET;
    end else if (CE) begin
      if (wr_stored) stored <= in_byte;
      if (wr_work) working <= in_byte;
    end
  end

  // both locks must be open; one cycle behind the arrays
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      WRITE_ALLOWED <= 1'b1;
    end else if (CE) begin
      WRITE_ALLOWED <= dyn_lock[sec_idx] & pers_lock[sec_idx];
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  a_dyn_clear: assert property ((wr_dyn && in_byte == slt_pkg::LOCK_ON) |=> !dyn_lock[$past(sec_idx)])
    else $error("dynamic lock not cleared by 00h");
  a_dyn_open: assert property ((wr_dyn && in_byte == slt_pkg::LOCK_OFF && pers_lock[sec_idx] && CE)
                               |=> dyn_lock[$past(sec_idx)] ##1 (!CE || WRITE_ALLOWED))
    else $error("dynamic FFh did not open sector");
  a_pers_code: assert property ((wr_pers && lock_valid(in_byte))
                                |=> pers_lock[$past(sec_idx)] == $past(in_byte == slt_pkg::LOCK_OFF))
    else $error("persistent lock code not applied");
  a_gate_protect: assert property ((CE && !(dyn_lock[sec_idx] && pers_lock[sec_idx])) |=> !WRITE_ALLOWED)
    else $error("write allowed on protected sector");
  a_pattern_load: assert property ($rose(state == slt_pkg::ST_DUMMY) |-> out_sr[63:56] == working)
    else $error("dummy shifter not loaded from working copy");
  a_pattern_drive: assert property ((state == slt_pkg::ST_DUMMY && sck_fall && pattern_on)
                                    |=> SO_OE && SO == $past(out_sr[63]))
    else $error("pattern bit not driven in dummy cycle");
  a_pattern_quiet: assert property ((state == slt_pkg::ST_DUMMY && sck_fall && !pattern_on)
                                    |=> !SO_OE)
    else $error("pattern driven while disabled");
  a_work_update: assert property (wr_work |=> working == $past(in_byte))
    else $error("working pattern write lost");
  a_ship_state: assert property ($fell(RST) |-> (&dyn_lock) && (&pers_lock) && stored == slt_pkg::STORED_RESET)
    else $error("delivery state wrong after reset");
  a_prot_reply: assert property ((op_done && in_byte == slt_pkg::CMD_RD_APR)
                                 |=> out_sr[63:48] == slt_pkg::APR_SHIP)
    else $error("protection register reply wrong");
  a_pass_reply: assert property ((op_done && in_byte == slt_pkg::CMD_RD_PASS) |=> out_sr == slt_pkg::PASS_SHIP)
    else $error("password reply wrong");
  a_cs_release: assert property (cs_end |=> !SO_OE && state == slt_pkg::ST_OPC)
    else $error("line not released at frame end");

  c_dyn_write:  cover property (wr_dyn && in_byte == slt_pkg::LOCK_ON);
  c_pers_write: cover property (wr_pers && in_byte == slt_pkg::LOCK_OFF);
  c_dummy_pat:  cover property ($rose(state == slt_pkg::ST_DUMMY) && pattern_on);
  c_otp_read:   cover property (addr_done && opcode == slt_pkg::CMD_RD_OTP);
endmodule : slt_top

// >>> dv/slt_host_model.sv
// host serial controller model that drives command frames at the device pins
`timescale 1ns/100ps
module slt_host_model (
  // clocking
  input  wire logic CLOCK,
  // serial link to the device
  output logic      SCK,
  output logic      CS_N,
  output logic      SI,
  input  wire logic SO,
  input  wire logic SO_OE
);
  // ==========================================================
  // idle pins: clock low, select high, link clock stands still
  initial begin
    SCK  = 1'b0;
    CS_N = 1'b1;
    SI   = 1'b0;
  end

  // released line has no pull: it reads back the opposite of the last drive
  wire so_line = SO_OE ? SO : ~SO;

  // ==========================================================
  // one frame: nout bits of tx msb first, then nin reply bits
  // pins move on falling CLOCK; 4 cycles per SCK phase, 160 ns per bit
  task automatic frame(input logic [47:0] tx, input int nout, input int nin,
                       output logic [63:0] rx, output logic [63:0] oe);
    rx = 64'h0;
    oe = 64'h0;
    @(negedge CLOCK);
    CS_N = 1'b0;
    for (int i = 0; i < nout + nin; i++) begin
      SCK = 1'b0;
      SI  = (i < nout) ? tx[47 - i] : 1'b0;
      repeat (4) @(negedge CLOCK);
      SCK = 1'b1;
      repeat (4) @(negedge CLOCK);
      // sample just before the next fall, while the bit still stands
      if (i >= nout) begin
        rx = {rx[62:0], so_line};
        oe = {oe[62:0], SO_OE};
      end
    end
    @(negedge CLOCK);
    SCK = 1'b0;
    repeat (4) @(negedge CLOCK);
    CS_N = 1'b1;
    SI   = ~SI;  // idle data line must not look held
    repeat (8) @(negedge CLOCK);
  endtask : frame
endmodule : slt_host_model

// >>> dv/tb_top.sv
// self-checking bench for the sector lock and training register bank
`timescale 1ns/100ps
module tb_top;
  // ==========================================================
  // signals
  logic        CLOCK;          // system clock
  logic        RST;            // synchronous reset
  logic        CE;             // clock enable, held high
  logic        SCK;            // link clock from host
  logic        CS_N;           // select from host
  logic        SI;             // data from host
  logic        SO;             // data to host
  logic        SO_OE;          // device drives SO
  logic        WRITE_ALLOWED;  // sector of last address open
  logic [63:0] rx;             // captured reply bits
  logic [63:0] oe;             // captured enable bits
  int          err_count = 0;  // mismatches
  int          checked   = 0;  // comparisons
  localparam logic [31:0] A3 = 32'h0003_0000;  // sector 3
  localparam logic [31:0] A4 = 32'h0004_0000;  // sector 4

  slt_top dut (.CLOCK(CLOCK), .RST(RST), .CE(CE), .SCK(SCK), .CS_N(CS_N), .SI(SI),
               .SO(SO), .SO_OE(SO_OE), .WRITE_ALLOWED(WRITE_ALLOWED));
  slt_host_model host (.CLOCK(CLOCK), .SCK(SCK), .CS_N(CS_N), .SI(SI), .SO(SO), .SO_OE(SO_OE));

  // ==========================================================
  // clock, 20 ns period
  initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end

  // ==========================================================
  // helpers
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  // read nb reply bytes; reply enable must stand for every bit
  task automatic rd(input logic [7:0] op, input logic [31:0] a, input int na, input int nb,
                    input logic [63:0] exp);
    logic [63:0] m;
    m = (64'h1 << (8 * nb)) - 64'h1;  // wraps to all ones for 8 bytes
    host.frame({op, a, 8'h00}, 8 + na, 8 * nb, rx, oe);
    check("reply", rx, exp);
    check("reply enable", oe, m);
  endtask : rd

  // write one data byte, with or without an address
  task automatic wr(input logic [7:0] op, input logic [31:0] a, input logic [7:0] d);
    if (op == 8'h4B || op == 8'h43)
      host.frame({op, d, 32'h0}, 16, 0, rx, oe);
    else
      host.frame({op, a, d}, 48, 0, rx, oe);
  endtask : wr

  // read with dummy clocks: pattern then one erased data byte
  task automatic ddr(input logic [7:0] pat);
    host.frame({8'hEE, A4, 8'h00}, 40, 16, rx, oe);
    // a disabled pattern leaves the line released: zeros read back inverted
    check("dummy pattern", {56'h0, rx[15:8]}, {56'h0, (pat != 8'h00) ? pat : 8'hFF});
    check("array byte", {56'h0, rx[7:0]}, 64'hFF);
    check("dummy enable", {48'h0, oe[15:0]}, {48'h0, (pat != 8'h00) ? 8'hFF : 8'h00, 8'hFF});
  endtask : ddr

  // ==========================================================
  // hang guard
  initial begin
    repeat (100000) @(posedge CLOCK);
    err_count++;
    complete_run();
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0]  ops [7] = '{8'h05, 8'h35, 8'h14, 8'h2B, 8'hE7, 8'h41, 8'h4A};
    int          nbs [7] = '{1, 1, 1, 2, 8, 1, 1};
    logic [63:0] exs [7] = '{64'h0, 64'h0, 64'h0, 64'hFE7F, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0, 64'h0};
    int          otp [4] = '{0, 15, 16, 1023};
    CE  = 1'b1;
    RST = 1'b1;
    repeat (3) @(negedge CLOCK);
    RST = 1'b0;
    repeat (6) @(negedge CLOCK);
    // delivery values of the fixed registers
    for (int i = 0; i < 7; i++)
      rd(ops[i], 32'h0, 0, nbs[i], exs[i]);
    rd(8'hE2, A3, 32, 1, 64'hFF);
    rd(8'hE0, A3, 32, 1, 64'hFF);
    for (int i = 0; i < 4; i++)
      rd(8'h4C, otp[i], 32, 1, (otp[i] < 16) ? {56'h0, slt_pkg::OTP_SEED[127 - 8 * otp[i] -: 8]} : 64'hFF);
    host.frame({8'h99, A3, 8'h00}, 40, 8, rx, oe);
    check("unknown opcode enable", oe, 64'h0);
    $display("test delivery done");
    // training pattern: disabled, then rewritten back to back
    ddr(8'h00);
    wr(8'h4B, 32'h0, 8'hA5);
    ddr(8'hA5);
    wr(8'h4B, 32'h0, 8'h3C);
    ddr(8'h3C);
    wr(8'h43, 32'h0, 8'h5A);
    rd(8'h41, 32'h0, 0, 1, 64'h5A);
    rd(8'h4A, 32'h0, 0, 1, 64'h3C);
    ddr(8'h3C);
    $display("test training done");
    // dynamic lock: set, refused value, reopen
    wr(8'hE1, A3, 8'h00);
    check("allowed after dyn lock", WRITE_ALLOWED, 1'b0);
    rd(8'hE0, A3, 32, 1, 64'h00);
    rd(8'hE0, A4, 32, 1, 64'hFF);
    check("allowed other sector", WRITE_ALLOWED, 1'b1);
    wr(8'hE1, A3, 8'h55);
    rd(8'hE0, A3, 32, 1, 64'h00);
    check("allowed still locked", WRITE_ALLOWED, 1'b0);
    wr(8'hE1, A3, 8'hFF);
    check("allowed after dyn open", WRITE_ALLOWED, 1'b1);
    $display("test dynamic lock done");
    // persistent lock alone blocks the sector
    wr(8'hE3, A3, 8'h00);
    check("allowed after pers lock", WRITE_ALLOWED, 1'b0);
    rd(8'hE2, A3, 32, 1, 64'h00);
    rd(8'hE0, A3, 32, 1, 64'hFF);
    check("allowed dyn open pers shut", WRITE_ALLOWED, 1'b0);
    wr(8'hE3, A3, 8'hFF);
    check("allowed after pers open", WRITE_ALLOWED, 1'b1);
    $display("test persistent lock done");
    // reset in mid run restores delivery state
    wr(8'hE3, A3, 8'h00);
    RST = 1'b1;
    repeat (3) @(negedge CLOCK);
    RST = 1'b0;
    repeat (6) @(negedge CLOCK);
    check("allowed after reset", WRITE_ALLOWED, 1'b1);
    rd(8'hE2, A3, 32, 1, 64'hFF);
    rd(8'h4A, 32'h0, 0, 1, 64'h00);
    $display("test reset done");
    complete_run();
  end
endmodule : tb_top
